// [design/qsb_pkg.sv]
// Package for the burst-of-two separate-port SRAM cycle logic.
// Assumes one system clock; the K and K# edges are modelled as
// alternating enable phases of that clock.
package qsb_pkg;

  // Organisation: four 9-bit byte lanes (36-bit); two lanes gives 18-bit
  localparam int BYTE_W    = 9;
  localparam int NUM_BYTES = 4;
  localparam int DATA_W    = BYTE_W * NUM_BYTES;
  localparam int ADDR_W    = 21;
  // Storage modelled by the low address bits only
  localparam int ARR_AW    = 8;
  localparam int ARR_DEPTH = 1 << ARR_AW;

  // System clock period and read latency in half K cycles
  localparam int CLK_PERIOD_NS = 8;
  localparam int RD_LAT_HALF   = 5;
  localparam int RD_TAP_FIRST  = RD_LAT_HALF - 1;
  localparam int RD_TAP_SECOND = RD_LAT_HALF;
  localparam int PIPE_LEN      = RD_LAT_HALF + 1;

  // Which input clock rises at the next running system edge
  typedef enum logic [0:0]
  {
    QSB_K_EDGE  = 1'h0,
    QSB_KN_EDGE = 1'h1
  } qsb_phase_t;

endpackage

// [design/qsb_sram_core.sv]
// Cycle logic of a burst-of-two separate-port synchronous SRAM.
// Assumes synchronous inputs; clk_run_i low models a stopped K clock.
`timescale 1ns/1ps

module qsb_sram_core
  import qsb_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  input  wire logic                 clk_run_i,
  input  wire logic                 rd_sel_n_i,
  input  wire logic                 wr_sel_n_i,
  input  wire logic [ADDR_W-1:0]    rd_addr_i,
  input  wire logic [ADDR_W-1:0]    wr_addr_i,
  input  wire logic [NUM_BYTES-1:0] byte_write_en_n_i,
  input  wire logic [DATA_W-1:0]    data_i,
  output logic      [DATA_W-1:0]    q_o,
  output logic                      q_oe_n_o
);

  // Lays buffered bytes over an array word where the address hits
  function automatic logic [DATA_W-1:0] merge_word
  (
    input logic [DATA_W-1:0]    base,
    input logic [DATA_W-1:0]    bdat,
    input logic [NUM_BYTES-1:0] bmask,
    input logic                 hit
  );
    logic [DATA_W-1:0] w;
    w = base;
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      if (hit && bmask[b])
      begin
        w[b*BYTE_W +: BYTE_W] = bdat[b*BYTE_W +: BYTE_W];
      end
    end
    return w;
  endfunction

  logic [DATA_W-1:0]    mem [ARR_DEPTH];
  qsb_phase_t           phase, next_phase;
  logic                 rd_blk, next_rd_blk;
  logic                 wr_blk, next_wr_blk;
  logic                 prev_idle, next_prev_idle;
  logic [PIPE_LEN-1:0]  pv, next_pv;
  logic [ARR_AW-1:0]    pa [PIPE_LEN];
  logic [ARR_AW-1:0]    next_pa [PIPE_LEN];
  logic                 wb_v, next_wb_v;
  logic [ARR_AW-1:0]    wb_a, next_wb_a;
  logic [DATA_W-1:0]    wb_d0, next_wb_d0, wb_d1, next_wb_d1;
  logic [NUM_BYTES-1:0] wb_m0, next_wb_m0, wb_m1, next_wb_m1;
  logic [DATA_W-1:0]    next_q;
  logic                 next_q_oe_n;
  logic                 k_edge, kn_edge, rd_req, rd_acc, wr_req, wr_acc;
  logic                 commit;
  logic [ARR_AW-1:0]    wb_a1, rd_a0, rd_a1;
  logic [DATA_W-1:0]    rd_word0, rd_word1;

  // Edge phases and command acceptance
  always_comb
  begin
    k_edge  = clk_run_i && (phase == QSB_K_EDGE);
    kn_edge = clk_run_i && (phase == QSB_KN_EDGE);
    rd_req  = k_edge && !rd_sel_n_i;
    rd_acc  = rd_req && !rd_blk;
    wr_req  = k_edge && !wr_sel_n_i;
    wr_acc  = wr_req && !wr_blk && !(prev_idle && !rd_sel_n_i);
    commit  = wr_acc && wb_v;
  end

  // Read address pair and coherent data lookup
  always_comb
  begin
    wb_a1    = wb_a + ARR_AW'(1);
    rd_a0    = pa[RD_TAP_FIRST];
    rd_a1    = pa[RD_TAP_SECOND] + ARR_AW'(1);
    rd_word0 = merge_word(merge_word(mem[rd_a0], wb_d0, wb_m0,
                                     wb_v && (rd_a0 == wb_a)),
                          wb_d1, wb_m1, wb_v && (rd_a0 == wb_a1));
    rd_word1 = merge_word(merge_word(mem[rd_a1], wb_d0, wb_m0,
                                     wb_v && (rd_a1 == wb_a)),
                          wb_d1, wb_m1, wb_v && (rd_a1 == wb_a1));
  end

  // Next values of control, pipeline, write buffer and outputs
  always_comb
  begin
    next_phase     = phase;
    next_rd_blk    = rd_blk;
    next_wr_blk    = wr_blk;
    next_prev_idle = prev_idle;
    next_pv        = pv;
    next_pa        = pa;
    next_wb_v      = wb_v;
    next_wb_a      = wb_a;
    next_wb_d0     = wb_d0;
    next_wb_d1     = wb_d1;
    next_wb_m0     = wb_m0;
    next_wb_m1     = wb_m1;
    next_q         = q_o;
    next_q_oe_n    = q_oe_n_o;
    if (clk_run_i)
    begin
      next_phase = (phase == QSB_K_EDGE) ? QSB_KN_EDGE : QSB_K_EDGE;
      // Read pipeline advances each half K cycle
      next_pv = {pv[PIPE_LEN-2:0], rd_acc};
      next_pa[0] = rd_addr_i[ARR_AW-1:0];
      for (int i = 1; i < PIPE_LEN; i++)
      begin
        next_pa[i] = pa[i-1];
      end
      if (pv[RD_TAP_FIRST])
      begin
        next_q      = rd_word0;
        next_q_oe_n = 1'h0;
      end
      else if (pv[RD_TAP_SECOND])
      begin
        next_q      = rd_word1;
        next_q_oe_n = 1'h0;
      end
      else
      begin
        next_q_oe_n = 1'h1;
      end
    end
    if (k_edge)
    begin
      next_rd_blk    = rd_acc;
      next_wr_blk    = wr_acc;
      next_prev_idle = rd_sel_n_i && wr_sel_n_i;
    end
    if (wr_acc)
    begin
      next_wb_v  = 1'h1;
      next_wb_a  = wr_addr_i[ARR_AW-1:0];
      next_wb_d0 = data_i;
      next_wb_m0 = ~byte_write_en_n_i;
      next_wb_m1 = {NUM_BYTES{1'h0}};
    end
    if (kn_edge && wr_blk)
    begin
      next_wb_d1 = data_i;
      next_wb_m1 = ~byte_write_en_n_i;
    end
  end

  // State registers
  always_ff @(posedge mclk_i)
  begin
    if (!nrst_i)
    begin
      phase     <= QSB_K_EDGE;
      rd_blk    <= 1'h0;
      wr_blk    <= 1'h0;
      prev_idle <= 1'h0;
      pv        <= {PIPE_LEN{1'h0}};
      for (int i = 0; i < PIPE_LEN; i++)
      begin
        pa[i] <= {ARR_AW{1'h0}};
      end
      wb_v      <= 1'h0;
      wb_a      <= {ARR_AW{1'h0}};
      wb_d0     <= {DATA_W{1'h0}};
      wb_d1     <= {DATA_W{1'h0}};
      wb_m0     <= {NUM_BYTES{1'h0}};
      wb_m1     <= {NUM_BYTES{1'h0}};
      q_o       <= {DATA_W{1'h0}};
      q_oe_n_o  <= 1'h1;
    end
    else
    begin
      phase     <= next_phase;
      rd_blk    <= next_rd_blk;
      wr_blk    <= next_wr_blk;
      prev_idle <= next_prev_idle;
      pv        <= next_pv;
      pa        <= next_pa;
      wb_v      <= next_wb_v;
      wb_a      <= next_wb_a;
      wb_d0     <= next_wb_d0;
      wb_d1     <= next_wb_d1;
      wb_m0     <= next_wb_m0;
      wb_m1     <= next_wb_m1;
      q_o       <= next_q;
      q_oe_n_o  <= next_q_oe_n;
    end
  end

  // Buffered write reaches the array when the next write is taken
  // buffer commit
  always_ff @(posedge mclk_i)
  begin
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      if (commit && wb_m0[b])
      begin
        mem[wb_a][b*BYTE_W +: BYTE_W] <= wb_d0[b*BYTE_W +: BYTE_W];
      end
      if (commit && wb_m1[b])
      begin
        mem[wb_a1][b*BYTE_W +: BYTE_W] <= wb_d1[b*BYTE_W +: BYTE_W];
      end
    end
  end

  // Checks on command handling and read timing
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_read_cmd;
    k_edge && !rd_sel_n_i && !rd_blk;
  endsequence

  sequence s_write_cmd;
    k_edge && !wr_sel_n_i && !wr_blk && !(prev_idle && !rd_sel_n_i);
  endsequence

  a_read_taken: assert property (s_read_cmd |=> pv[0] && rd_blk)
    else $error("read command not taken");
  a_write_taken: assert property
    (s_write_cmd |=> wb_v && wr_blk && (wb_d0 == $past(data_i)))
    else $error("write command not taken");
  a_first_word: assert property
    (clk_run_i && pv[RD_TAP_FIRST] |=> !q_oe_n_o && q_o == $past(rd_word0))
    else $error("first read word wrong");
  a_second_word: assert property
    (clk_run_i && pv[RD_TAP_SECOND] && !pv[RD_TAP_FIRST]
      |=> !q_oe_n_o && q_o == $past(rd_word1))
    else $error("second read word wrong");
  a_idle_hiz: assert property
    (clk_run_i && pv[RD_TAP_SECOND:RD_TAP_FIRST] == 2'h0 |=> q_oe_n_o)
    else $error("output not released when idle");
  a_stop_hold: assert property
    (!clk_run_i |=> $stable(q_o) && $stable(q_oe_n_o) && $stable(pv))
    else $error("state moved while clock stopped");
  a_read_gap: assert property
    (s_read_cmd ##2 k_edge |-> !rd_acc)
    else $error("back-to-back read accepted");
  a_write_gap: assert property (k_edge && wr_blk |-> !wr_acc)
    else $error("back-to-back write accepted");
  a_read_wins: assert property
    (k_edge && prev_idle && !rd_sel_n_i && !wr_sel_n_i |-> rd_acc != wr_acc)
    else $error("write kept after idle collision");
  a_abort_beat: assert property
    ((s_write_cmd and (&byte_write_en_n_i)) |=> wb_m0 == {NUM_BYTES{1'h0}})
    else $error("aborted beat not masked");

endmodule

// [testbench/qsb_ctrl_model.sv]
// Controller model driving the SRAM command and write data ports.
// Assumes each command is started by the caller on a K edge.
`timescale 1ns/1ps

module qsb_ctrl_model
  import qsb_pkg::*;
(
  input  wire logic                 mclk_i,
  output logic                      clk_run_o,
  output logic                      rd_sel_n_o,
  output logic                      wr_sel_n_o,
  output logic [ADDR_W-1:0]         rd_addr_o,
  output logic [ADDR_W-1:0]         wr_addr_o,
  output logic [NUM_BYTES-1:0]      byte_write_en_n_o,
  output logic [DATA_W-1:0]         data_o
);

  // Quiet bus at time zero
  initial
  begin
    clk_run_o = 1'h1;
    rd_sel_n_o = 1'h1;
    wr_sel_n_o = 1'h1;
    rd_addr_o = '0;
    wr_addr_o = '0;
    byte_write_en_n_o = '1;
    data_o = '0;
  end

  // One edge of selects, beat and enables
  task automatic beat(input logic r, input logic w,
    input logic [ADDR_W-1:0] ra, input logic [ADDR_W-1:0] wa,
    input logic [DATA_W-1:0] d, input logic [NUM_BYTES-1:0] e);
    rd_sel_n_o = r;
    wr_sel_n_o = w;
    rd_addr_o = ra;
    wr_addr_o = wa;
    data_o = d;
    byte_write_en_n_o = e;
    @(posedge mclk_i);
    #1;
  endtask

  // Addresses and data show the inverse of their last value; selects and byte enables go high
  task automatic idle();
    beat(1'h1, 1'h1, ~rd_addr_o, ~wr_addr_o, ~data_o, '1);
  endtask

  task automatic stop(input int n);
    clk_run_o = 1'h0;
    repeat (n - 1) beat(1'h0, 1'h0, '0, '0, ~data_o, '0);
    // Selects released on the last stopped edge, not with the restart
    beat(1'h1, 1'h1, '0, '0, ~data_o, '1);
    clk_run_o = 1'h1;
  endtask

endmodule

// [testbench/tb_top.sv]
// Self-checking bench for the burst-of-two SRAM cycle logic.
// Assumes the controller model drives every device input except the clock and reset.
`timescale 1ns/1ps

module tb_top
  import qsb_pkg::*;
;
  logic                 mclk_i;
  logic                 nrst_i;
  logic                 clk_run;
  logic                 rd_sel_n;
  logic                 wr_sel_n;
  logic [ADDR_W-1:0]    rd_addr;
  logic [ADDR_W-1:0]    wr_addr;
  logic [NUM_BYTES-1:0] be_n;
  logic [DATA_W-1:0]    wdata;
  logic [DATA_W-1:0]    q;
  logic                 q_oe_n;
  logic [DATA_W-1:0]    mem [ARR_DEPTH];
  int                   errors;
  int                   checks;

  // Free-running system clock
  initial
  begin
    mclk_i = 1'h0;
    forever #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  end

  qsb_sram_core u_qsb_sram_core (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .clk_run_i(clk_run),
    .rd_sel_n_i(rd_sel_n), .wr_sel_n_i(wr_sel_n),
    .rd_addr_i(rd_addr), .wr_addr_i(wr_addr),
    .byte_write_en_n_i(be_n), .data_i(wdata),
    .q_o(q), .q_oe_n_o(q_oe_n));

  qsb_ctrl_model u_qsb_ctrl_model (
    .mclk_i(mclk_i), .clk_run_o(clk_run),
    .rd_sel_n_o(rd_sel_n), .wr_sel_n_o(wr_sel_n),
    .rd_addr_o(rd_addr), .wr_addr_o(wr_addr),
    .byte_write_en_n_o(be_n), .data_o(wdata));

  // Compare and count
  task automatic chk(input string n, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    checks++;
    if (e !== g)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask

  // Two-beat write, two idle edges, shadow updated per byte lane
  task automatic wr(input logic [7:0] a, input logic [DATA_W-1:0] d0,
    input logic [NUM_BYTES-1:0] e0, input logic [DATA_W-1:0] d1,
    input logic [NUM_BYTES-1:0] e1);
    logic [7:0] a1;
    a1 = a + 8'h01;
    u_qsb_ctrl_model.beat(1'h1, 1'h0, '0, ADDR_W'(a), d0, e0);
    u_qsb_ctrl_model.beat(1'h1, 1'h1, '0, '0, d1, e1);
    u_qsb_ctrl_model.idle();
    u_qsb_ctrl_model.idle();
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      if (!e0[b]) mem[a][b*BYTE_W +: BYTE_W] = d0[b*BYTE_W +: BYTE_W];
      if (!e1[b]) mem[a1][b*BYTE_W +: BYTE_W] = d1[b*BYTE_W +: BYTE_W];
    end
  endtask

  // Read, optionally with a write on the same edge; checks the burst
  task automatic rd(input logic [7:0] a, input logic col,
                    input logic [7:0] w);
    u_qsb_ctrl_model.beat(1'h0, ~col, ADDR_W'(a), ADDR_W'(w), ~mem[w], '0);
    repeat (4)
    begin
      u_qsb_ctrl_model.idle();
      chk("oe_n_wait", DATA_W'(1'h1), DATA_W'(q_oe_n)); // Idle
    end
    u_qsb_ctrl_model.idle();
    chk("oe_n_w0", DATA_W'(1'h0), DATA_W'(q_oe_n)); // Latency
    chk("q_w0", mem[a], q); // First word
    u_qsb_ctrl_model.idle();
    chk("q_w1", mem[8'(a + 8'h01)], q); // Next address
    u_qsb_ctrl_model.idle();
    chk("oe_n_end", DATA_W'(1'h1), DATA_W'(q_oe_n)); // Two words
  endtask

  // Each byte lane written alone in beat 0 with beat 1 aborted, then beat 0 aborted with beat 1 written
  task automatic t_lanes();
    for (int b = 0; b < NUM_BYTES; b++)
    begin
      wr(8'(8'h40 + 2 * b), '1, '0, '1, '0); // Fill
      wr(8'(8'h40 + 2 * b), '0, NUM_BYTES'(~(1 << b)), '0, '1);
      rd(8'(8'h40 + 2 * b), 1'h0, 8'h00); // Lane masks
    end
    wr(8'h50, '1, '0, '1, '0); // Fill
    wr(8'h50, '0, '1, '0, '0); // Beat 0 aborted
    rd(8'h50, 1'h0, 8'h00); // Only beat 1 lands
  endtask

  // Second read and second write one K edge later are dropped
  task automatic t_b2b();
    u_qsb_ctrl_model.beat(1'h1, 1'h0, '0, ADDR_W'(8'h30), '1, '0);
    u_qsb_ctrl_model.beat(1'h1, 1'h1, '0, '0, '0, '0);
    u_qsb_ctrl_model.beat(1'h1, 1'h0, '0, ADDR_W'(8'h20), '0, '0);
    u_qsb_ctrl_model.idle();
    mem[8'h30] = '1;
    mem[8'h31] = '0;
    u_qsb_ctrl_model.beat(1'h0, 1'h1, ADDR_W'(8'h30), '0, '0, '1);
    u_qsb_ctrl_model.idle();
    u_qsb_ctrl_model.beat(1'h0, 1'h1, ADDR_W'(8'h20), '0, '1, '1);
    repeat (3) u_qsb_ctrl_model.idle();
    chk("b2b_w0", mem[8'h30], q); // First read only
    u_qsb_ctrl_model.idle();
    chk("b2b_w1", mem[8'h31], q); // First read only
    repeat (2)
    begin
      u_qsb_ctrl_model.idle();
      chk("b2b_oe_n", DATA_W'(1'h1), DATA_W'(q_oe_n)); // Dropped
    end
    u_qsb_ctrl_model.idle();
    rd(8'h20, 1'h0, 8'h00); // Old data kept
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog against a hung run
  initial
  begin
    #(CLK_PERIOD_NS * 5000);
    errors++;
    results();
  end

  // Main sequence
  initial
  begin
    errors = 0;
    checks = 0;
    nrst_i = 1'h0;
    repeat (3) @(posedge mclk_i);
    #1;
    nrst_i = 1'h1;
    wr(8'h10, 36'hA5A5A5A5A, '0, 36'h5A5A5A5A5, '0); // Write
    rd(8'h10, 1'h0, 8'h00); // Buffered data
    wr(8'h20, 36'h123456789, '0, 36'h9ABCDEF01, '0); // Write
    t_lanes(); // Byte lanes
    t_b2b(); // Command spacing
    rd(8'h10, 1'h1, 8'h20); // Read wins
    rd(8'h20, 1'h0, 8'h00); // Write dropped
    u_qsb_ctrl_model.stop(6); // Clock stop
    chk("stop_oe_n", DATA_W'(1'h1), DATA_W'(q_oe_n)); // Held
    rd(8'h42, 1'h0, 8'h00); // Phase kept
    results();
  end

endmodule
